// >>> pkg/crcu_pkg.sv
// Package for the CRC computing unit: register map, field layout, reset values,
// polynomial and access width codes.
// Assumes a 32-bit Avalon-MM slave port with byte addresses and one clock.
package crcu_pkg;

  // Byte offsets of the registers on the slave port.
  localparam logic [4:0] CRCU_OFF_DATA    = 5'h00;
  localparam logic [4:0] CRCU_OFF_SCRATCH = 5'h04;
  localparam logic [4:0] CRCU_OFF_CTRL    = 5'h08;
  localparam logic [4:0] CRCU_OFF_SEED    = 5'h10;

  // Address width of the slave port in bits.
  localparam int CRCU_ADDR_W = 5;

  // Control register field positions.
  localparam int CRCU_CTRL_RST_BIT  = 0;
  localparam int CRCU_CTRL_INPUT_REVERSE_SEL_LSB = 5;
  localparam int CRCU_CTRL_INPUT_REVERSE_SEL_MSB = 6;
  localparam int CRCU_CTRL_OUTPUT_REVERSE_EN_BIT = 7;

  // Reset values.
  localparam logic [31:0] CRCU_RST_DATA    = 32'hFFFF_FFFF;
  localparam logic [7:0]  CRCU_RST_SCRATCH = 8'h00;
  localparam logic [1:0]  CRCU_RST_INPUT_REVERSE_SEL    = 2'h0;
  localparam logic        CRCU_RST_OUTPUT_REVERSE_EN    = 1'b0;
  localparam logic [31:0] CRCU_RST_SEED    = 32'hFFFF_FFFF;
  localparam logic [31:0] CRCU_RST_RDATA   = 32'h0000_0000;

  // Fixed generator polynomial, normal (non-reflected) form.
  localparam logic [31:0] CRCU_POLY = 32'h04C1_1DB7;

  // Byte enable patterns that the data register accepts.
  localparam logic [3:0] CRCU_BE_WORD = 4'hF;
  localparam logic [3:0] CRCU_BE_HALF = 4'h3;
  localparam logic [3:0] CRCU_BE_BYTE = 4'h1;

  // Depth of the input buffer in front of the engine.
  localparam int CRCU_BUF_DEPTH = 2;

  // Width of one input unit: access width code plus 32 data bits.
  localparam int CRCU_UNIT_W = 34;

  // Access width codes carried with each buffered word.
  typedef enum logic [1:0] {
    CRCU_W8   = 2'b00,
    CRCU_W16  = 2'b01,
    CRCU_W32  = 2'b10,
    CRCU_WBAD = 2'b11
  } crcu_width_e;

  // Input reversal selections.
  localparam logic [1:0] CRCU_REV_NONE = 2'b00;
  localparam logic [1:0] CRCU_REV_BYTE = 2'b01;
  localparam logic [1:0] CRCU_REV_HALF = 2'b10;
  localparam logic [1:0] CRCU_REV_WORD = 2'b11;

endpackage

// >>> pkg/crcu_stream_if.sv
// Valid/ready stream carrier used between the CRC unit's own modules.
// Assumes both ends run on the same clock; a word moves when valid and ready are high.
`timescale 1ns/1ps
interface crcu_stream_if #(
  parameter int WIDTH = 34
);
  logic             valid;  // Source holds a word.
  logic             ready;  // Sink can take a word.
  logic [WIDTH-1:0] data;   // The word itself.

  // Producing end.
  modport src (
    output valid,
    output data,
    input  ready
  );

  // Consuming end.
  modport snk (
    input  valid,
    input  data,
    output ready
  );
endinterface

// >>> hw/crcu_pair_buf.sv
// Small first-in first-out buffer with valid and ready on both sides.
// Assumes one clock; the filling side only pushes while ready is high.
`timescale 1ns/1ps
module crcu_pair_buf import crcu_pkg::*; #(
  parameter int WIDTH = CRCU_UNIT_W,
  parameter int DEPTH = CRCU_BUF_DEPTH
) (
  input  wire logic  clk,
  input  wire logic  rst_b,
  crcu_stream_if.snk fill,
  crcu_stream_if.src drain
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] store [DEPTH];  // Entries, addressed by pointer.
  logic [PTR_W-1:0] wr_ptr;         // Next entry to fill.
  logic [PTR_W-1:0] rd_ptr;         // Oldest entry.
  logic [CNT_W-1:0] level;          // Entries held.

  wire do_push = fill.valid & fill.ready;
  wire do_pop  = drain.valid & drain.ready;

  // Full and empty come straight from the level, so back-pressure is exact.
  assign fill.ready  = (level != CNT_W'(DEPTH));
  assign drain.valid = (level != '0);
  assign drain.data  = store[rd_ptr];

  // Pointer wrap, written generally so the depth may be any value.
  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    bump = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Entry storage; the contents need no reset since level guards them.
  always_ff @(posedge clk) begin
    if (do_push) begin
      store[wr_ptr] <= fill.data;
    end
  end

  // Pointers and level.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (do_pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      if (do_push && !do_pop) begin
        level <= level + 1'b1;
      end else if (!do_push && do_pop) begin
        level <= level - 1'b1;
      end
    end
  end

endmodule

// >>> hw/crcu_top.sv
// CRC computing unit: Avalon-MM register slave, input buffer and a byte-serial
// CRC engine with input and output bit reversal.
// Assumes a single 25 MHz clock, a synchronous active-low reset and a bus master
// that holds each request until it sees waitrequest low.
//
// Functional notes
// - Fixed Ethernet CRC-32 polynomial, not programmable.
// - Word write finishes within four clocks.
// - Half-word write finishes within two clocks.
// - Byte write finishes within one clock.
// - Each data write with a legal lane pattern folds into the running result.
// - Data register takes word, half, byte writes.
// - Data register read returns current CRC result.
// - Scratch byte stores data, untouched by unit reset.
// - Reset bit reloads result, self clears.
// - Input reversal by none, byte, half, word.
// - Output reversal bit mirrors result on reads.
// - Writable seed register gives the starting value.
// - Data writes buffered so bus rarely stalls.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module crcu_top import crcu_pkg::*; #(
  parameter int BUF_DEPTH = CRCU_BUF_DEPTH
) (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic [CRCU_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  output logic                        crc_busy
);

  // Engine states.
  typedef enum logic [1:0] {
    CRCU_ST_IDLE = 2'b00,
    CRCU_ST_RUN  = 2'b01
  } crcu_state_e;

  // Software visible state.
  logic [31:0] crc;                // Running CRC result.
  logic [31:0] seed_value;         // Starting value for a new computation.
  logic [7:0]  scratch_byte_field; // General purpose byte.
  logic [1:0]  input_reverse_sel;  // Input reversal unit.
  logic        output_reverse_en;  // Mirror the result on reads.

  // Engine state.
  crcu_state_e state;              // Idle or still folding bytes.
  logic [31:0] shreg;              // Remaining input bytes, top byte next.
  logic [1:0]  bytes_left;         // Bytes still to fold after this one.

  // Carriers between the slave, the buffer and the engine.
  crcu_stream_if #(.WIDTH(CRCU_UNIT_W)) push_if ();
  crcu_stream_if #(.WIDTH(CRCU_UNIT_W)) pop_if ();

  // One CRC step over eight input bits, most significant bit first.
  function automatic logic [31:0] crc_step8(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    logic        fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[31] ^ d[i];
      r  = {r[30:0], 1'b0} ^ (fb ? CRCU_POLY : 32'h0000_0000);
    end
    crc_step8 = r;
  endfunction

  // Mirror a whole 32-bit word, bit 0 swapping with bit 31.
  function automatic logic [31:0] mirror32(input logic [31:0] v);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[31-i];
    end
    mirror32 = r;
  endfunction

  // Access width from byte enables; only right-aligned patterns are legal.
  function automatic crcu_width_e be_width(input logic [3:0] be);
    case (be)
      CRCU_BE_WORD: be_width = CRCU_W32;
      CRCU_BE_HALF: be_width = CRCU_W16;
      CRCU_BE_BYTE: be_width = CRCU_W8;
      default:      be_width = CRCU_WBAD;
    endcase
  endfunction

  // Number of bytes minus one for a width code.
  function automatic logic [1:0] width_bytes_m1(input logic [1:0] w);
    case (w)
      CRCU_W32: width_bytes_m1 = 2'd3;
      CRCU_W16: width_bytes_m1 = 2'd1;
      default:  width_bytes_m1 = 2'd0;
    endcase
  endfunction

  // Prepare an input unit: left-align the written bits so the top byte goes
  // first, then mirror inside each reversal unit. A unit wider than the access
  // is trimmed to the access width, so a byte write in word mode mirrors the byte.
  function automatic logic [31:0] prep_input(input logic [31:0] d, input logic [1:0] w,
                                             input logic [1:0] sel);
    logic [31:0] a;
    logic [31:0] r;
    logic [1:0]  eff;
    case (w)
      CRCU_W32: a = d;
      CRCU_W16: a = {d[15:0], 16'h0000};
      default:  a = {d[7:0], 24'h00_0000};
    endcase
    eff = sel;
    if (w == CRCU_W8 && sel != CRCU_REV_NONE) begin
      eff = CRCU_REV_BYTE;
    end else if (w == CRCU_W16 && sel == CRCU_REV_WORD) begin
      eff = CRCU_REV_HALF;
    end
    r = a;
    case (eff)
      CRCU_REV_BYTE: begin
        for (int i = 0; i < 32; i++) begin
          r[i] = a[(i & ~7) + 7 - (i & 7)];
        end
      end
      CRCU_REV_HALF: begin
        for (int i = 0; i < 32; i++) begin
          r[i] = a[(i & ~15) + 15 - (i & 15)];
        end
      end
      CRCU_REV_WORD: r = mirror32(a);
      default:       r = a;
    endcase
    prep_input = r;
  endfunction

  // Address decode.
  wire sel_data    = (avs_address == CRCU_OFF_DATA);
  wire sel_scratch = (avs_address == CRCU_OFF_SCRATCH);
  wire sel_ctrl    = (avs_address == CRCU_OFF_CTRL);
  wire sel_seed    = (avs_address == CRCU_OFF_SEED);

  // A request is new while waitrequest is still high; the low cycle is its answer.
  wire new_req  = (avs_read | avs_write) & avs_waitrequest;
  wire do_write = avs_write & ~avs_waitrequest;

  // Engine is quiet: nothing running and nothing queued.
  wire engine_idle = (state == CRCU_ST_IDLE) & ~pop_if.valid;

  // Wait states: data writes wait for a free buffer entry, control writes and
  // data reads wait until every queued word has been folded in.
  wire data_wr_ok = push_if.ready;
  wire can_answer = (avs_write & sel_data) ? data_wr_ok :
                    ((avs_write & sel_ctrl) | (avs_read & sel_data)) ? engine_idle :
                    1'b1;
  wire next_answer = new_req & can_answer;

  // Read multiplexer; unmapped offsets and reserved bits read as zero.
  wire [31:0] ctrl_word = {24'h00_0000, output_reverse_en, input_reverse_sel, 5'h00};
  wire [31:0] crc_view  = output_reverse_en ? mirror32(crc) : crc;
  wire [31:0] rd_mux    = sel_data    ? crc_view :
                          sel_scratch ? {24'h00_0000, scratch_byte_field} :
                          sel_ctrl    ? ctrl_word :
                          sel_seed    ? seed_value :
                          32'h0000_0000;

  // Width of the data write, taken from the byte lanes.
  wire crcu_width_e wr_width = be_width(avs_byteenable);

  // Data writes enter the buffer at the edge the master sees the answer.
  // Illegal lane patterns are answered but dropped.
  assign push_if.valid = do_write & sel_data & (wr_width != CRCU_WBAD);
  assign push_if.data  = {wr_width, avs_writedata};

  // The engine takes a new unit only when it has finished the last one.
  assign pop_if.ready = (state == CRCU_ST_IDLE);
  wire        pop_fire  = pop_if.valid & pop_if.ready;
  wire [1:0]  pop_width = pop_if.data[33:32];
  wire [31:0] pop_prep  = prep_input(pop_if.data[31:0], pop_width, input_reverse_sel);

  // Unit reset request from the control register.
  wire unit_reset = do_write & sel_ctrl & avs_writedata[CRCU_CTRL_RST_BIT];

  // Input buffer.
  crcu_pair_buf #(
    .WIDTH (CRCU_UNIT_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk   (clk),
    .rst_b (rst_b),
    .fill  (push_if),
    .drain (pop_if)
  );

  // Bus answer: waitrequest drops for exactly one cycle per request, and read
  // data is registered in the same cycle so both stand at the sampling edge.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= CRCU_RST_RDATA;
    end else begin
      avs_waitrequest <= ~next_answer;
      if (next_answer && avs_read) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // Scratch byte; the unit reset does not reach it.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scratch_byte_field <= CRCU_RST_SCRATCH;
    end else if (do_write && sel_scratch) begin
      scratch_byte_field <= avs_writedata[7:0];
    end
  end

  // Control fields. Lane enables are ignored here because full words are
  // expected; the reset bit itself is not stored, so it always reads zero.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      input_reverse_sel <= CRCU_RST_INPUT_REVERSE_SEL;
      output_reverse_en <= CRCU_RST_OUTPUT_REVERSE_EN;
    end else if (do_write && sel_ctrl) begin
      input_reverse_sel <= avs_writedata[CRCU_CTRL_INPUT_REVERSE_SEL_MSB:CRCU_CTRL_INPUT_REVERSE_SEL_LSB];
      output_reverse_en <= avs_writedata[CRCU_CTRL_OUTPUT_REVERSE_EN_BIT];
    end
  end

  // Seed value register.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      seed_value <= CRCU_RST_SEED;
    end else if (do_write && sel_seed) begin
      seed_value <= avs_writedata;
    end
  end

  // Running result. A unit reset is only answered while the engine is idle,
  // so it can never collide with a byte step.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      crc <= CRCU_RST_DATA;
    end else if (unit_reset) begin
      crc <= seed_value;
    end else if (pop_fire) begin
      crc <= crc_step8(crc, pop_prep[31:24]);
    end else if (state == CRCU_ST_RUN) begin
      crc <= crc_step8(crc, shreg[31:24]);
    end
  end

  // Engine sequencing: one byte per clock, so a byte needs one clock, a half
  // word two and a word four, counted from the clock it leaves the buffer.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state      <= CRCU_ST_IDLE;
      shreg      <= 32'h0000_0000;
      bytes_left <= 2'd0;
    end else begin
      case (state)
        CRCU_ST_IDLE: begin
          if (pop_fire) begin
            shreg      <= {pop_prep[23:0], 8'h00};
            bytes_left <= width_bytes_m1(pop_width);
            if (width_bytes_m1(pop_width) != 2'd0) begin
              state <= CRCU_ST_RUN;
            end
          end
        end
        CRCU_ST_RUN: begin
          shreg      <= {shreg[23:0], 8'h00};
          bytes_left <= bytes_left - 2'd1;
          if (bytes_left == 2'd1) begin
            state <= CRCU_ST_IDLE;
          end
        end
        default: begin
          state <= CRCU_ST_IDLE;
        end
      endcase
    end
  end

  // Busy flag for the outside: work queued or in progress.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      crc_busy <= 1'b0;
    end else begin
      crc_busy <= ~engine_idle | push_if.valid;
    end
  end

endmodule

// >>> dv/crcu_properties.sv
// Checker for the CRC unit's bus port and busy flag.
// Assumes it is bound to crcu_top and sees only that module's ports.
`timescale 1ns/1ps
module crcu_properties import crcu_pkg::*; (
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire logic [CRCU_ADDR_W-1:0] avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_writedata,
  input wire logic [3:0]             avs_byteenable,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  input wire logic                   crc_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic data_ack;  // Answered data write with a legal lane pattern.
  logic read_ack;  // Answered read of any address.
  logic unmapped;  // Address outside the register map.
  assign data_ack = avs_write && !avs_waitrequest && avs_address == CRCU_OFF_DATA &&
                    (avs_byteenable inside {CRCU_BE_WORD, CRCU_BE_HALF, CRCU_BE_BYTE});
  assign read_ack = avs_read && !avs_waitrequest;
  assign unmapped = !(avs_address inside {CRCU_OFF_DATA, CRCU_OFF_SCRATCH, CRCU_OFF_CTRL, CRCU_OFF_SEED});
  // A data write taken while the engine is idle, so its fold time starts at once.
  sequence s_idle_take(logic [3:0] be);
    data_ack && avs_byteenable == be && !crc_busy;
  endsequence
  // Busy covers the buffer cycle and the fold itself; a later data write only stretches it.
  a_byte_fold: assert property (s_idle_take(CRCU_BE_BYTE) |=> crc_busy[*2])
    else $error("byte fold dropped busy early");
  // Busy may only fall on time when no further data write keeps the engine going.
  a_byte_done: assert property (s_idle_take(CRCU_BE_BYTE) ##1 (!data_ack)[*2] |=> !crc_busy)
    else $error("byte fold too slow");
  a_half_fold: assert property (s_idle_take(CRCU_BE_HALF) |=> crc_busy[*3])
    else $error("half fold dropped busy early");
  a_half_done: assert property (s_idle_take(CRCU_BE_HALF) ##1 (!data_ack)[*3] |=> !crc_busy)
    else $error("half fold too slow");
  a_word_fold: assert property (s_idle_take(CRCU_BE_WORD) |=> crc_busy[*5])
    else $error("word fold dropped busy early");
  a_word_done: assert property (s_idle_take(CRCU_BE_WORD) ##1 (!data_ack)[*5] |=> !crc_busy)
    else $error("word fold too slow");
  a_busy_cause: assert property ($rose(crc_busy) |-> $past(data_ack, 2) || $past(data_ack))
    else $error("busy without a data write");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_ack_has_req: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  a_unmapped_zero: assert property (read_ack && unmapped |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_rst_bit_clear: assert property (read_ack && avs_address == CRCU_OFF_CTRL |-> !avs_readdata[0])
    else $error("unit reset bit reads one");
  a_scratch_width: assert property (read_ack && avs_address == CRCU_OFF_SCRATCH |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("scratch upper bits set");
  a_read_hold: assert property (!$stable(avs_readdata) |-> read_ack)
    else $error("read data moved outside an answer");
endmodule
bind crcu_top crcu_properties u_props (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .crc_busy(crc_busy));

// >>> dv/crcu_bus_master.sv
// Avalon-MM master model standing in for the processor.
// Assumes one clock; each request is held until waitrequest is sampled low.
`timescale 1ns/1ps
module crcu_bus_master import crcu_pkg::*; (
  input  wire logic                   clk,
  output logic [CRCU_ADDR_W-1:0]      avs_address,
  output logic                        avs_read,
  output logic                        avs_write,
  output logic [31:0]                 avs_writedata,
  output logic [3:0]                  avs_byteenable,
  input  wire logic [31:0]            avs_readdata,
  input  wire logic                   avs_waitrequest
);
  // Idle bus at time zero.
  initial begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
  end
  // One write; lanes narrower than a word only go to the data register.
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= (a == CRCU_OFF_DATA) ? be : CRCU_BE_WORD;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_writedata <= ~d;  // Released data must not look valid.
  endtask
  // One full-word read; data is taken at the answering edge.
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_byteenable <= CRCU_BE_WORD;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
  endtask
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the CRC unit with a reference model in functions.
// Assumes the bus master model drives every bus input of the design.
`timescale 1ns/1ps
module tb_top import crcu_pkg::*; ;
  logic                   clk;
  logic                   rst_b;
  logic [CRCU_ADDR_W-1:0] addr;
  logic                   rd_req;
  logic                   wr_req;
  logic [31:0]            wdata;
  logic [3:0]             be;
  logic [31:0]            rdata;
  logic                   wait_req;
  int                     checks;      // Comparisons made.
  int                     num_errors;  // Mismatches seen.
  logic [31:0]            rs;          // Random state.
  logic [31:0]            crc;         // Expected running result.
  logic [31:0]            v;           // Value read back.
  initial clk = 1'b0;
  always #20 clk = ~clk;
  crcu_top DUT (.clk(clk), .rst_b(rst_b), .avs_address(addr), .avs_read(rd_req), .avs_write(wr_req),
    .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wait_req), .crc_busy());
  crcu_bus_master u_host (.clk(clk), .avs_address(addr), .avs_read(rd_req), .avs_write(wr_req),
    .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wait_req));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Fold n bits, most significant first, into the running result.
  function automatic logic [31:0] fold(input logic [31:0] c, input logic [31:0] d, input int n);
    for (int i = n - 1; i >= 0; i--) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? CRCU_POLY : 32'h0000_0000);
    return c;
  endfunction
  // Mirror bits inside each unit; a unit wider than the access is trimmed to it.
  function automatic logic [31:0] rev_in(input logic [31:0] d, input int n, input logic [1:0] s);
    int u;
    logic [31:0] r;
    u = (s == 2'b00) ? 1 : (4 << s);
    if (u > n) u = n;
    r = d;
    for (int i = 0; i < n; i++) r[i] = d[(i / u) * u + u - 1 - i % u];
    return r;
  endfunction
  function automatic logic [31:0] mirror(input logic [31:0] c);
    logic [31:0] r;
    for (int i = 0; i < 32; i++) r[i] = c[31 - i];
    return r;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Data write of width code w (0 byte, 1 half, 2 word) and its model update.
  task automatic put(input logic [31:0] d, input int w, input logic [1:0] ri);
    u_host.wr(CRCU_OFF_DATA, d, (w == 2) ? CRCU_BE_WORD : (w == 1) ? CRCU_BE_HALF : CRCU_BE_BYTE);
    crc = fold(crc, rev_in(d, 8 << w, ri), 8 << w);
  endtask
  task automatic rd_check(input logic [4:0] a, input logic [31:0] e);
    u_host.rd(a, v);
    check(v, e);
  endtask
  // Watchdog sized well above the several hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test();
  end
  initial begin
    rst_b = 1'b0;
    checks = 0;
    num_errors = 0;
    rs = 32'ha931;
    crc = CRCU_RST_DATA;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd_check(CRCU_OFF_DATA, 32'hFFFF_FFFF);
    rd_check(CRCU_OFF_SCRATCH, 32'h0000_0000);
    rd_check(CRCU_OFF_CTRL, 32'h0000_0000);
    rd_check(CRCU_OFF_SEED, 32'hFFFF_FFFF);
    $display("test reset_values done");
    // Every reversal mode with random seeds, widths and data, back to back.
    for (int m = 0; m < 8; m++) begin
      rs = lfsr(rs);
      crc = rs;
      u_host.wr(CRCU_OFF_SEED, rs, CRCU_BE_WORD);
      u_host.wr(CRCU_OFF_CTRL, {24'h00_0000, m[2], m[1:0], 5'h01}, CRCU_BE_WORD);
      rd_check(CRCU_OFF_SEED, crc);
      for (int k = 0; k < 6; k++) begin
        rs = lfsr(rs);
        put(rs, rs[9:8] % 3, m[1:0]);
      end
      rd_check(CRCU_OFF_DATA, m[2] ? mirror(crc) : crc);
      rd_check(CRCU_OFF_CTRL, {24'h00_0000, m[2], m[1:0], 5'h00});
    end
    $display("test random_modes done");
    // Unit reset from the reset seed, then each width alone with scratch traffic between.
    u_host.wr(CRCU_OFF_SEED, 32'hFFFF_FFFF, CRCU_BE_WORD);
    u_host.wr(CRCU_OFF_CTRL, 32'h0000_0001, CRCU_BE_WORD);
    crc = 32'hFFFF_FFFF;
    rd_check(CRCU_OFF_DATA, crc);
    for (int w = 0; w < 3; w++) begin
      put(32'hA5C3_0F96 ^ w, w, 2'b00);
      u_host.wr(CRCU_OFF_SCRATCH, 32'h0000_015A + w, CRCU_BE_WORD);
      rd_check(CRCU_OFF_DATA, crc);
      rd_check(CRCU_OFF_SCRATCH, 32'h0000_005A + w);
    end
    // A unit reset reloads the result and must leave the scratch byte alone.
    u_host.wr(CRCU_OFF_CTRL, 32'h0000_0001, CRCU_BE_WORD);
    crc = 32'hFFFF_FFFF;
    rd_check(CRCU_OFF_SCRATCH, 32'h0000_005C);
    rd_check(CRCU_OFF_DATA, crc);
    $display("test widths done");
    // Words back to back fill the buffer; a bad lane pattern is dropped.
    // Words arrive faster than the engine folds them, so the buffer fills and the bus stalls.
    for (int k = 0; k < 12; k++) put(32'h1357_9BDF + k, 2, 2'b00);
    u_host.wr(CRCU_OFF_DATA, 32'hFFFF_FFFF, 4'h2);
    rd_check(CRCU_OFF_DATA, crc);
    $display("test buffer done");
    // Unmapped places read zero and swallow writes.
    u_host.wr(5'h0C, 32'hDEAD_BEEF, CRCU_BE_WORD);
    rd_check(5'h0C, 32'h0000_0000);
    rd_check(5'h1C, 32'h0000_0000);
    rd_check(CRCU_OFF_DATA, crc);
    $display("test unmapped done");
    stop_test();
  end
endmodule
